// ---- core/homing_pkg.sv ----
/*
 * Shared definitions for the homing sequencer: method codes, input bit
 * positions, motion encodings, event and state enumerations, carriers.
 * Assumes one 125 MHz clock domain and that all switch and index levels
 * are synchronised before the sequencer looks at them.
 */
package homing_pkg;

    // Method codes on the method select input
    localparam logic [3:0] M_NLIM_IDX = 4'h1;
    localparam logic [3:0] M_PLIM_IDX = 4'h2;
    localparam logic [3:0] M_ORG_P_A = 4'h3;
    localparam logic [3:0] M_ORG_P_B = 4'h4;
    localparam logic [3:0] M_ORG_N_A = 4'h5;
    localparam logic [3:0] M_ORG_N_B = 4'h6;
    localparam logic [3:0] M_ORGLIM_1 = 4'h7;
    localparam logic [3:0] M_ORGLIM_2 = 4'h8;
    localparam logic [3:0] M_ORGLIM_3 = 4'h9;
    localparam logic [3:0] M_ORGLIM_4 = 4'hA;

    // Bit positions in the sensor vector
    localparam int SENSE_W = 4;
    localparam int IN_NLIM = 0;
    localparam int IN_PLIM = 1;
    localparam int IN_ORG = 2;
    localparam int IN_IDX = 3;

    // Motion encodings
    localparam logic DIR_POS = 1'b1;
    localparam logic DIR_NEG = 1'b0;
    localparam logic SPD_FAST = 1'b1;
    localparam logic SPD_SLOW = 1'b0;

    // Position word width
    localparam int POS_W = 32;
    localparam logic [POS_W-1:0] POS_RST = 32'h0000_0000;

    // Number of steps in one homing plan
    localparam int STEPS = 4;

    // Event that ends a step
    typedef enum logic [2:0] {
        EV_NLIM_RISE,
        EV_NLIM_FALL,
        EV_PLIM_RISE,
        EV_PLIM_FALL,
        EV_ORG_RISE,
        EV_ORG_FALL,
        EV_INDEX
    } event_t;

    // Which branch of a method runs, picked at start or on a limit
    typedef enum logic [1:0] {
        BR_CLEAR,
        BR_ACTIVE,
        BR_LIMIT
    } branch_t;

    // Sequencer phase
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MOVE
    } hstate_t;

    // One step of a plan: motion plus the event that ends it
    typedef struct packed {
        logic dir;
        logic fast;
        event_t ev;
    } step_t;

    typedef step_t [STEPS-1:0] plan_t;

    // Motion command towards the drive
    typedef struct packed {
        logic run;
        logic dir;
        logic fast;
    } motion_t;

    // Sensor edge carrier from the synchroniser
    typedef struct packed {
        logic [SENSE_W-1:0] level;
        logic [SENSE_W-1:0] rise;
        logic [SENSE_W-1:0] fall;
    } sense_t;

    // Whole sequencer state
    typedef struct packed {
        hstate_t st;
        logic [3:0] method;
        branch_t br;
        logic [1:0] ph;
        motion_t mot;
        logic done;
        logic err;
        logic [POS_W-1:0] home_pos;
    } seq_state_t;

endpackage

// ---- core/edge_sync.sv ----
/*
 * Two-flop synchroniser with edge detection for the sensor pins.
 * Assumes the pins are asynchronous levels; pulses must stay high for
 * longer than one clock period to be seen.
 */
`timescale 1ns/10ps
module edge_sync
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Raw pins
    input wire logic [homing_pkg::SENSE_W-1:0] pins,
    // Synchronised levels and one-cycle edges
    output homing_pkg::sense_t sense
);

    // First stage, second stage, and previous level
    typedef struct packed {
        logic [homing_pkg::SENSE_W-1:0] s1;
        logic [homing_pkg::SENSE_W-1:0] s2;
        logic [homing_pkg::SENSE_W-1:0] s3;
    } sync_t;

    sync_t q_r;
    sync_t q_nxt;

    // Shift chain; s1 feeds only s2 to keep metastability contained
    always_comb
    begin
        q_nxt = q_r;
        q_nxt.s1 = pins;
        q_nxt.s2 = q_r.s1;
        q_nxt.s3 = q_r.s2;
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q_r <= '0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    // Edges compare the two settled stages only
    assign sense.level = q_r.s2;
    assign sense.rise = q_r.s2 & ~q_r.s3;
    assign sense.fall = ~q_r.s2 & q_r.s3;

endmodule // edge_sync

// ---- core/homing_sequencer.sv ----
/*
 * Homing sequencer for one servo axis, methods 1 to 10.
 * Assumes switch and index pins are asynchronous and active high, the
 * start and abort requests and the position count come from logic on
 * core_clk, and the drive ramps speed and direction by itself.
 */
// Overview of operation
// - M1 clear: fast neg, nlim rise reverses
// - M1 active: slow pos, index after nlim fall
// - M2 clear: fast pos, plim rise reverses
// - M2 active: slow neg, index after plim fall
// - M3: origin rise reverses, index after fall
// - M4: origin rise slows, index follows
// - M5: fast neg, reverse slow, index after fall
// - M6: fast neg slows, index after origin
// - M7 without limit behaves as method 3
// - M7 limit: fast neg, slow at origin
// - M8: ends slow pos after origin rise
// - M8 limit branch: reverse, then as method 8
// - M9: ends slow neg after origin rise
// - M9 limit branch: reverse thrice, index after rise
// - M10: slow past origin, index after fall
// - M10 limit: fast neg, slow pos, index
`timescale 1ns/10ps
module homing_sequencer
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Requests from the controlling side
    input wire logic start,
    input wire logic abort,
    input wire logic [3:0] method,
    // Sensor pins
    input wire logic neg_limit,
    input wire logic pos_limit,
    input wire logic origin_sw,
    input wire logic enc_index,
    // Encoder position count
    input wire logic [homing_pkg::POS_W-1:0] pos_count,
    // Motion command
    output logic run,
    output logic dir_pos,
    output logic fast,
    // Status
    output logic busy,
    output logic done,
    output logic bad_method,
    output logic [homing_pkg::POS_W-1:0] home_pos
);

    // Synchronised sensor levels and edges
    homing_pkg::sense_t sense;

    // Sequencer state and its next value
    homing_pkg::seq_state_t s_r;
    homing_pkg::seq_state_t s_nxt;

    // Current plan and step, decoded from state
    homing_pkg::plan_t cur_plan;
    homing_pkg::step_t cur_step;

    // Build one step
    function automatic homing_pkg::step_t mk(
        input logic d,
        input logic f,
        input homing_pkg::event_t e
    );
        homing_pkg::step_t st;
        st.dir = d;
        st.fast = f;
        st.ev = e;
        return st;
    endfunction

    // Plan table; unused trailing steps just wait for the index
    function automatic homing_pkg::plan_t plan_of(
        input logic [3:0] m,
        input homing_pkg::branch_t b
    );
        homing_pkg::plan_t p;
        logic P;
        logic N;
        logic F;
        logic S;
        P = homing_pkg::DIR_POS;
        N = homing_pkg::DIR_NEG;
        F = homing_pkg::SPD_FAST;
        S = homing_pkg::SPD_SLOW;
        for (int i = 0; i < homing_pkg::STEPS; i++)
        begin
            p[i] = mk(N, S, homing_pkg::EV_INDEX);
        end
        unique case (m)
            homing_pkg::M_NLIM_IDX:
            begin
                if (b == homing_pkg::BR_CLEAR)
                begin
                    p[0] = mk(N, F, homing_pkg::EV_NLIM_RISE);
                    p[1] = mk(P, S, homing_pkg::EV_NLIM_FALL);
                    p[2] = mk(P, S, homing_pkg::EV_INDEX);
                end
                else
                begin
                    p[0] = mk(P, S, homing_pkg::EV_NLIM_FALL);
                    p[1] = mk(P, S, homing_pkg::EV_INDEX);
                end
            end
            homing_pkg::M_PLIM_IDX:
            begin
                if (b == homing_pkg::BR_CLEAR)
                begin
                    p[0] = mk(P, F, homing_pkg::EV_PLIM_RISE);
                    p[1] = mk(N, S, homing_pkg::EV_PLIM_FALL);
                    p[2] = mk(N, S, homing_pkg::EV_INDEX);
                end
                else
                begin
                    p[0] = mk(N, S, homing_pkg::EV_PLIM_FALL);
                    p[1] = mk(N, S, homing_pkg::EV_INDEX);
                end
            end
            homing_pkg::M_ORG_P_A, homing_pkg::M_ORGLIM_1:
            begin
                // Method 7 reuses method 3 until a limit shows up
                if (b == homing_pkg::BR_CLEAR)
                begin
                    p[0] = mk(P, F, homing_pkg::EV_ORG_RISE);
                    p[1] = mk(N, S, homing_pkg::EV_ORG_FALL);
                end
                else if (b == homing_pkg::BR_ACTIVE)
                begin
                    p[0] = mk(N, S, homing_pkg::EV_ORG_FALL);
                end
                else
                begin
                    p[0] = mk(N, F, homing_pkg::EV_ORG_RISE);
                    p[1] = mk(N, S, homing_pkg::EV_ORG_FALL);
                end
            end
            homing_pkg::M_ORG_P_B:
            begin
                if (b == homing_pkg::BR_CLEAR)
                begin
                    p[0] = mk(P, F, homing_pkg::EV_ORG_RISE);
                    p[1] = mk(P, S, homing_pkg::EV_INDEX);
                end
                else
                begin
                    p[0] = mk(N, S, homing_pkg::EV_ORG_FALL);
                    p[1] = mk(P, S, homing_pkg::EV_ORG_RISE);
                    p[2] = mk(P, S, homing_pkg::EV_INDEX);
                end
            end
            homing_pkg::M_ORG_N_A:
            begin
                if (b == homing_pkg::BR_CLEAR)
                begin
                    p[0] = mk(N, F, homing_pkg::EV_ORG_RISE);
                    p[1] = mk(P, S, homing_pkg::EV_ORG_FALL);
                    p[2] = mk(P, S, homing_pkg::EV_INDEX);
                end
                else
                begin
                    p[0] = mk(P, S, homing_pkg::EV_ORG_FALL);
                    p[1] = mk(P, S, homing_pkg::EV_INDEX);
                end
            end
            homing_pkg::M_ORG_N_B:
            begin
                if (b == homing_pkg::BR_CLEAR)
                begin
                    p[0] = mk(N, F, homing_pkg::EV_ORG_RISE);
                end
                else
                begin
                    // Index counts once the origin is met again
                    p[0] = mk(P, S, homing_pkg::EV_ORG_FALL);
                    p[1] = mk(N, S, homing_pkg::EV_ORG_RISE);
                end
            end
            homing_pkg::M_ORGLIM_2:
            begin
                if (b == homing_pkg::BR_CLEAR)
                begin
                    p[0] = mk(P, F, homing_pkg::EV_ORG_RISE);
                    p[1] = mk(N, S, homing_pkg::EV_ORG_FALL);
                    p[2] = mk(P, S, homing_pkg::EV_ORG_RISE);
                    p[3] = mk(P, S, homing_pkg::EV_INDEX);
                end
                else if (b == homing_pkg::BR_ACTIVE)
                begin
                    p[0] = mk(N, S, homing_pkg::EV_ORG_FALL);
                    p[1] = mk(P, S, homing_pkg::EV_ORG_RISE);
                    p[2] = mk(P, S, homing_pkg::EV_INDEX);
                end
                else
                begin
                    p[0] = mk(N, F, homing_pkg::EV_ORG_RISE);
                    p[1] = mk(N, S, homing_pkg::EV_ORG_FALL);
                    p[2] = mk(P, S, homing_pkg::EV_ORG_RISE);
                    p[3] = mk(P, S, homing_pkg::EV_INDEX);
                end
            end
            homing_pkg::M_ORGLIM_3:
            begin
                if (b == homing_pkg::BR_CLEAR)
                begin
                    p[0] = mk(P, F, homing_pkg::EV_ORG_RISE);
                    p[1] = mk(P, S, homing_pkg::EV_ORG_FALL);
                    p[2] = mk(N, S, homing_pkg::EV_ORG_RISE);
                end
                else if (b == homing_pkg::BR_ACTIVE)
                begin
                    p[0] = mk(P, S, homing_pkg::EV_ORG_FALL);
                    p[1] = mk(N, S, homing_pkg::EV_ORG_RISE);
                end
                else
                begin
                    p[0] = mk(N, F, homing_pkg::EV_ORG_RISE);
                    p[1] = mk(P, S, homing_pkg::EV_ORG_FALL);
                    p[2] = mk(N, S, homing_pkg::EV_ORG_RISE);
                end
            end
            homing_pkg::M_ORGLIM_4:
            begin
                if (b == homing_pkg::BR_CLEAR)
                begin
                    p[0] = mk(P, F, homing_pkg::EV_ORG_RISE);
                    p[1] = mk(P, S, homing_pkg::EV_ORG_FALL);
                    p[2] = mk(P, S, homing_pkg::EV_INDEX);
                end
                else if (b == homing_pkg::BR_ACTIVE)
                begin
                    p[0] = mk(P, S, homing_pkg::EV_ORG_FALL);
                    p[1] = mk(P, S, homing_pkg::EV_INDEX);
                end
                else
                begin
                    p[0] = mk(N, F, homing_pkg::EV_ORG_RISE);
                    p[1] = mk(P, S, homing_pkg::EV_ORG_FALL);
                    p[2] = mk(P, S, homing_pkg::EV_INDEX);
                end
            end
            default:
            begin
                // Illegal code never runs; table stays at its fill
            end
        endcase
        return p;
    endfunction

    // Has the awaited event occurred this cycle
    function automatic logic ev_hit(
        input homing_pkg::event_t e,
        input homing_pkg::sense_t sn
    );
        logic h;
        h = 1'b0;
        unique case (e)
            homing_pkg::EV_NLIM_RISE: h = sn.rise[homing_pkg::IN_NLIM];
            homing_pkg::EV_NLIM_FALL: h = sn.fall[homing_pkg::IN_NLIM];
            homing_pkg::EV_PLIM_RISE: h = sn.rise[homing_pkg::IN_PLIM];
            homing_pkg::EV_PLIM_FALL: h = sn.fall[homing_pkg::IN_PLIM];
            homing_pkg::EV_ORG_RISE: h = sn.rise[homing_pkg::IN_ORG];
            homing_pkg::EV_ORG_FALL: h = sn.fall[homing_pkg::IN_ORG];
            homing_pkg::EV_INDEX: h = sn.rise[homing_pkg::IN_IDX];
            default: h = 1'b0;
        endcase
        return h;
    endfunction

    // Motion command for a step
    function automatic homing_pkg::motion_t drive(
        input homing_pkg::step_t st
    );
        homing_pkg::motion_t mo;
        mo.run = 1'b1;
        mo.dir = st.dir;
        mo.fast = st.fast;
        return mo;
    endfunction

    // Pin synchroniser and edge finder
    edge_sync u_sync
    (
        .core_clk(core_clk),
        .nrst(nrst),
        .pins({enc_index, origin_sw, pos_limit, neg_limit}),
        .sense(sense)
    );

    // Decode the running step
    always_comb
    begin
        cur_plan = plan_of(s_r.method, s_r.br);
        cur_step = cur_plan[s_r.ph];
    end

    // Next state
    always_comb
    begin
        homing_pkg::plan_t np;
        homing_pkg::branch_t nb;
        np = '0;
        nb = homing_pkg::BR_CLEAR;
        s_nxt = s_r;
        s_nxt.err = 1'b0;
        unique case (s_r.st)
            homing_pkg::ST_IDLE:
            begin
                if (start && (method >= homing_pkg::M_NLIM_IDX)
                    && (method <= homing_pkg::M_ORGLIM_4))
                begin
                    // Starting level picks the branch
                    if (method == homing_pkg::M_NLIM_IDX)
                        nb = sense.level[homing_pkg::IN_NLIM] ?
                            homing_pkg::BR_ACTIVE : homing_pkg::BR_CLEAR;
                    else if (method == homing_pkg::M_PLIM_IDX)
                        nb = sense.level[homing_pkg::IN_PLIM] ?
                            homing_pkg::BR_ACTIVE : homing_pkg::BR_CLEAR;
                    else
                        nb = sense.level[homing_pkg::IN_ORG] ?
                            homing_pkg::BR_ACTIVE : homing_pkg::BR_CLEAR;
                    np = plan_of(method, nb);
                    s_nxt.st = homing_pkg::ST_MOVE;
                    s_nxt.method = method;
                    s_nxt.br = nb;
                    s_nxt.ph = 2'd0;
                    s_nxt.mot = drive(np[0]);
                    s_nxt.done = 1'b0;
                end
                else if (start)
                begin
                    // Unsupported code: refuse, report for one cycle
                    s_nxt.err = 1'b1;
                end
            end
            homing_pkg::ST_MOVE:
            begin
                if (abort)
                begin
                    // Stop without a home; done stays low
                    s_nxt.st = homing_pkg::ST_IDLE;
                    s_nxt.mot = '0;
                end
                else if (s_r.method >= homing_pkg::M_ORGLIM_1
                    && s_r.br == homing_pkg::BR_CLEAR && s_r.ph == 2'd0
                    && sense.rise[homing_pkg::IN_PLIM])
                begin
                    // Positive limit in the fast search: limit branch
                    np = plan_of(s_r.method, homing_pkg::BR_LIMIT);
                    s_nxt.br = homing_pkg::BR_LIMIT;
                    s_nxt.ph = 2'd0;
                    s_nxt.mot = drive(np[0]);
                end
                else if (cur_step.ev == homing_pkg::EV_INDEX)
                begin
                    if (ev_hit(cur_step.ev, sense))
                    begin
                        // Home found: stop, latch, report
                        s_nxt.st = homing_pkg::ST_IDLE;
                        s_nxt.mot = '0;
                        s_nxt.home_pos = pos_count;
                        s_nxt.done = 1'b1;
                    end
                end
                else if (ev_hit(cur_step.ev, sense))
                begin
                    // Awaited edge: advance to the next step
                    s_nxt.ph = s_r.ph + 2'd1;
                    s_nxt.mot = drive(cur_plan[s_r.ph + 2'd1]);
                end
            end
            default:
            begin
                s_nxt.st = homing_pkg::ST_IDLE;
                s_nxt.mot = '0;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_r <= '{st: homing_pkg::ST_IDLE, method: 4'h0,
                br: homing_pkg::BR_CLEAR, ph: 2'd0, mot: '0,
                done: 1'b0, err: 1'b0, home_pos: homing_pkg::POS_RST};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs are state fields
    assign run = s_r.mot.run;
    assign dir_pos = s_r.mot.dir;
    assign fast = s_r.mot.fast;
    assign busy = s_r.mot.run; // Run is set exactly while moving
    assign done = s_r.done;
    assign bad_method = s_r.err;
    assign home_pos = s_r.home_pos;

endmodule // homing_sequencer

// ---- tb/homing_assertions.sv ----
/*
 * Port checker for the homing sequencer.
 * Assumes one clock, core_clk, and the async active low reset nrst.
 */
`timescale 1ns/10ps
module homing_checker
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Requests
    input wire logic start,
    input wire logic abort,
    input wire logic [3:0] method,
    // Sensors and position
    input wire logic neg_limit,
    input wire logic pos_limit,
    input wire logic origin_sw,
    input wire logic enc_index,
    input wire logic [homing_pkg::POS_W-1:0] pos_count,
    // Motion and status
    input wire logic run,
    input wire logic dir_pos,
    input wire logic fast,
    input wire logic busy,
    input wire logic done,
    input wire logic bad_method,
    input wire logic [homing_pkg::POS_W-1:0] home_pos
);
    // One domain, so clock and disable are given once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Start taken while idle
    wire logic go = start && !busy;

    a_m1_clear: assert property (go && method == 4'h1 && !neg_limit
        && !$past(neg_limit, 3) |=> run && !dir_pos && fast && busy)
        else $error("method 1 clear start not fast negative");
    a_m1_active: assert property (go && method == 4'h1 && neg_limit
        && $past(neg_limit, 3) |=> run && dir_pos && !fast)
        else $error("method 1 active start not slow positive");
    a_m2_clear: assert property (go && method == 4'h2 && !pos_limit
        && !$past(pos_limit, 3) |=> run && dir_pos && fast)
        else $error("method 2 clear start not fast positive");
    a_m3_clear: assert property (go && method == 4'h3 && !origin_sw
        && !$past(origin_sw, 3) |=> run && dir_pos && fast)
        else $error("method 3 clear start not fast positive");
    a_m5_clear: assert property (go && method == 4'h5 && !origin_sw
        && !$past(origin_sw, 3) |=> run && !dir_pos && fast)
        else $error("method 5 clear start not fast negative");
    a_home_latch: assert property ($rose(done) |->
        !run && !busy && home_pos == $past(pos_count))
        else $error("home did not stop and latch position");
    a_home_index: assert property ($rose(done) |->
        $past(enc_index, 2) && !fast)
        else $error("home taken without index pulse");
    a_start_clear: assert property (go && method >= 4'h1
        && method <= 4'hA |=> busy && !done && !bad_method)
        else $error("valid start not accepted");
    a_done_idle: assert property (done |-> !run && !busy)
        else $error("done raised while axis still moving");
endmodule // homing_checker

bind homing_sequencer homing_checker u_chk (.core_clk, .nrst, .start,
    .abort, .method, .neg_limit, .pos_limit, .origin_sw, .enc_index,
    .pos_count, .run, .dir_pos, .fast, .busy, .done, .bad_method,
    .home_pos);

// ---- tb/axis_model.sv ----
/*
 * Behavioural axis: position moves with the motion command and the
 * switches and index follow from where the axis stands.
 * Assumes the same core_clk as the sequencer; no reset of its own.
 */
`timescale 1ns/10ps
module axis_model
(
    // Clock
    input wire logic core_clk,
    // Motion command
    input wire logic run,
    input wire logic dir_pos,
    input wire logic fast,
    // Position preset from the bench
    input wire logic load,
    input wire logic signed [31:0] load_pos,
    // Sensor levels and count
    output logic neg_limit,
    output logic pos_limit,
    output logic origin_sw,
    output logic enc_index,
    output logic [31:0] pos_count
);
    // Track layout in counts
    localparam int NLIM = -1000;
    localparam int PLIM = 1000;
    localparam int ORG_LO = 200;
    localparam int ORG_HI = 300;
    // Axis position
    logic signed [31:0] pos = 32'sh0000_0000;

    // Fast moves 4 counts a cycle, slow 1, so index stays >= 4 cycles
    always @(posedge core_clk)
    begin
        if (load)
            pos <= load_pos;
        else if (run)
            pos <= pos + (dir_pos ? 1 : -1) * (fast ? 4 : 1);
    end

    // Levels held as long as the axis stays in the zone
    assign neg_limit = (pos <= NLIM);
    assign pos_limit = (pos >= PLIM);
    assign origin_sw = (pos >= ORG_LO) && (pos <= ORG_HI);
    // Index every 128 counts, 16 counts wide
    assign enc_index = (pos[6:0] < 7'h10);
    assign pos_count = pos;
endmodule // axis_model

// ---- tb/testbench.sv ----
/*
 * Self-checking bench for the homing sequencer, methods 1 to 10.
 * Assumes axis_model stands for switches, index and encoder.
 */
`timescale 1ns/10ps
module testbench;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    logic abort = 1'b0;
    logic [3:0] method = 4'h0;
    logic load = 1'b0;
    logic signed [31:0] load_pos = 32'sh0000_0000;
    logic neg_limit, pos_limit, origin_sw, enc_index;
    logic [31:0] pos_count, home_pos;
    logic run, dir_pos, fast, busy, done, bad_method;
    // Motion log: 2 bits {dir,fast} per step, step 0 lowest
    logic [7:0] seq;
    logic [1:0] last;
    int n;
    int bad_cnt = 0;
    int failures = 0;
    int cmp_count = 0;

    // 125 MHz clock
    always #4 core_clk = ~core_clk;

    homing_sequencer dut (.core_clk(core_clk), .nrst(nrst),
        .start(start), .abort(abort), .method(method),
        .neg_limit(neg_limit), .pos_limit(pos_limit),
        .origin_sw(origin_sw), .enc_index(enc_index),
        .pos_count(pos_count), .run(run), .dir_pos(dir_pos), .fast(fast),
        .busy(busy), .done(done), .bad_method(bad_method),
        .home_pos(home_pos));
    axis_model axis (.core_clk(core_clk), .run(run), .dir_pos(dir_pos),
        .fast(fast), .load(load), .load_pos(load_pos),
        .neg_limit(neg_limit), .pos_limit(pos_limit),
        .origin_sw(origin_sw), .enc_index(enc_index),
        .pos_count(pos_count));

    // Log motion on the falling edge, where outputs have settled
    always @(negedge core_clk)
    begin
        if (busy === 1'b1 && run === 1'b1 && n < 4
            && (n == 0 || {dir_pos, fast} !== last))
        begin
            seq[2*n +: 2] = {dir_pos, fast};
            last = {dir_pos, fast};
            n = n + 1;
        end
        if (bad_method === 1'b1)
            bad_cnt = bad_cnt + 1;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Place the axis, let the synchroniser settle, then start
    task automatic begin_run(input logic [3:0] m, input int p);
        @(posedge core_clk);
        load <= 1'b1;
        load_pos <= p;
        @(posedge core_clk);
        load <= 1'b0;
        repeat (6) @(posedge core_clk);
        n = 0;
        seq = 8'h00;
        method <= m;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        @(posedge core_clk);
    endtask

    // Full run; motion log {step count, codes} must match the plan
    task automatic home(input logic [3:0] m, input int p,
        input logic [11:0] exp);
        int i;
        begin_run(m, p);
        i = 0;
        while (done !== 1'b1 && i < 20000)
        begin
            @(posedge core_clk);
            i++;
        end
        #1;
        check({busy, run, done}, 32'h0000_0001);
        check({25'h0, home_pos[6:0]} < 32'h0000_0014, 32'h0000_0001);
        check({n[3:0], seq}, exp);
    endtask

    // Codes per step: 3 fast pos, 2 slow pos, 1 fast neg, 0 slow neg
    task automatic sc_limits();
        home(4'h1, 0, 12'h209);
        home(4'h1, -1010, 12'h102);
        home(4'h2, 0, 12'h203);
        home(4'h2, 1010, 12'h100);
    endtask

    task automatic sc_origin();
        home(4'h3, 0, 12'h203);
        home(4'h3, 250, 12'h100);
        home(4'h4, 0, 12'h20B);
        home(4'h4, 250, 12'h208);
        home(4'h5, 500, 12'h209);
        home(4'h5, 250, 12'h102);
        home(4'h6, 500, 12'h201);
        home(4'h6, 250, 12'h202);
    endtask

    task automatic sc_orglim();
        home(4'h7, 0, 12'h203);
        home(4'h7, 250, 12'h100);
        home(4'h7, 500, 12'h307);
        home(4'h8, 0, 12'h323);
        home(4'h8, 250, 12'h208);
        home(4'h8, 500, 12'h487);
        home(4'h9, 0, 12'h30B);
        home(4'h9, 250, 12'h202);
        home(4'h9, 500, 12'h427);
        home(4'hA, 0, 12'h20B);
        home(4'hA, 250, 12'h102);
        home(4'hA, 500, 12'h327);
    endtask

    // Codes 0 and 11 are refused: one-cycle pulse, no motion
    task automatic sc_bad_code();
        bad_cnt = 0;
        begin_run(4'h0, 0);
        @(posedge core_clk);
        #1;
        check({busy, run, bad_method, bad_cnt[3:0]}, 32'h0000_0001);
        bad_cnt = 0;
        begin_run(4'hB, 0);
        @(posedge core_clk);
        #1;
        check({busy, run, bad_method, bad_cnt[3:0]}, 32'h0000_0001);
    endtask

    // Abort mid-search stops motion without a home
    task automatic sc_abort();
        begin_run(4'h1, 0);
        repeat (30) @(posedge core_clk);
        abort <= 1'b1;
        @(posedge core_clk);
        abort <= 1'b0;
        @(posedge core_clk);
        #1;
        check({busy, run, done}, 32'h0000_0000);
    endtask

    // Hang guard: well above the longest expected run
    initial
    begin
        repeat (90000) @(posedge core_clk);
        failures++;
        stop_test();
    end

    initial
    begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (5) @(posedge core_clk);
        sc_limits();
        sc_origin();
        sc_orglim();
        sc_bad_code();
        sc_abort();
        stop_test();
    end
endmodule // testbench
